// [src/fcp_pkg.sv]
// constants for the floppy command interpreter and port map
package fcp_pkg;
    // register indices; byte address is four times the index
    localparam logic [3:0] IDX_MON_A    = 4'h0;
    localparam logic [3:0] IDX_MON_B    = 4'h1;
    localparam logic [3:0] IDX_MOTOR    = 4'h2;
    localparam logic [3:0] IDX_TAPE     = 4'h3;
    localparam logic [3:0] IDX_FLOW     = 4'h4;
    localparam logic [3:0] IDX_DATA     = 4'h5;
    localparam logic [3:0] IDX_CHANGE   = 4'h7;
    localparam logic [3:0] IDX_IRQ_STAT = 4'h8;
    localparam logic [3:0] IDX_IRQ_MASK = 4'h9;
    localparam logic [3:0] IDX_MODE     = 4'hA;

    // opcodes
    localparam logic [7:0] OP_SEEK      = 8'h0F;
    localparam logic [5:0] OP_RSEEK_LOW = 6'h0F;
    localparam logic [7:0] OP_CONFIG    = 8'h13;
    localparam logic [7:0] OP_DUMP      = 8'h0E;
    localparam logic [7:0] OP_PERP      = 8'h12;
    localparam logic [6:0] OP_LOCK_LOW  = 7'h14;
    localparam logic [7:0] OP_SENSE     = 8'h04;
    localparam logic [7:0] INVALID_ST0  = 8'h80;

    // reset values; queue_disable (bit 5) set so the fifo starts off
    localparam logic [7:0] CFG_RST      = 8'h20;
    localparam logic [7:0] PRECOMP_START_CYLINDER_RST   = 8'h00;
    localparam logic [7:0] TIMING_RST   = 8'h00;
    localparam logic [7:0] MODEB_RST    = 8'h00;
    localparam logic [7:0] SECT_RST     = 8'h00;

    // interrupt status bits
    localparam int IRQ_W       = 3;
    localparam int IRQ_SEEK    = 0;
    localparam int IRQ_RESULT  = 1;
    localparam int IRQ_INVALID = 2;

    // timing
    localparam int CLK_MHZ       = 40;
    localparam int STEP_PULSE_NS = 100;
    localparam int STEP_PULSE_CYC = (STEP_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int STEP_RATE_US  = 3000;
    localparam int STEP_RATE_CYC = STEP_RATE_US * CLK_MHZ;

    localparam int RES_MAX = 10;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_PARAM  = 2'b01,
        ST_EXEC   = 2'b11,
        ST_RESULT = 2'b10
    } fcp_state_e;
endpackage

// [src/fcp_stepper.sv]
// head stepper: moves one track per step period toward a target
module fcp_stepper #(
    parameter int RATE_CYC  = 120000,
    parameter int PULSE_CYC = 4
) (
    input  wire logic       clk,         // system clock
    input  wire logic       rst_n,       // async reset, active low
    input  wire logic       start,       // load and begin a move
    input  wire logic [7:0] start_track, // present track
    input  wire logic [7:0] target,      // track to reach
    output logic            step_ff,     // step pulse
    output logic            dir_ff,      // 1 inward
    output logic            busy_ff,     // move in progress
    output logic            done_ff,     // one-cycle finish pulse
    output logic [7:0]      track_ff     // present track
);
    localparam int CW = $clog2(RATE_CYC + 1);

    initial begin
        if (PULSE_CYC < 1 || PULSE_CYC >= RATE_CYC)
            $error("step pulse must be shorter than step period");
    end

    logic [CW-1:0] cnt_ff;
    logic [7:0]    tgt_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff   <= '0;
            tgt_ff   <= 8'h00;
            track_ff <= 8'h00;
            busy_ff  <= 1'b0;
            done_ff  <= 1'b0;
            dir_ff   <= 1'b0;
            step_ff  <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (start) begin
                track_ff <= start_track;
                tgt_ff   <= target;
                busy_ff  <= 1'b1;
                cnt_ff   <= '0;
            end else if (busy_ff) begin
                if (cnt_ff == CW'(RATE_CYC - PULSE_CYC))
                    step_ff <= 1'b0;
                if (cnt_ff != '0) begin
                    cnt_ff <= cnt_ff - CW'(1);
                end else if (track_ff == tgt_ff) begin
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                end else begin
                    step_ff  <= 1'b1;
                    dir_ff   <= (tgt_ff > track_ff);
                    track_ff <= (tgt_ff > track_ff) ? track_ff + 8'h01
                                                    : track_ff - 8'h01;
                    cnt_ff   <= CW'(RATE_CYC - 1);
                end
            end
        end
    end
endmodule

// [src/fcp_top.sv]
// floppy command interpreter with apb port map and drive status
//
// Overview of operation
// - seek moves selected head to target cylinder
// - dump returns tracks, timing, mode, sector bytes
// - dump mode byte: lock, zero, enables, gap, gate
// - sense drive status returns one status byte
// - unknown opcode returns 80h and idles
// - decode offsets 0-5 and 7-10 as mapped
// - status port A mirrors pins, two layouts
// - status A bit 7 shows interrupt line
// - status A bit 6 shows second unit when model30_ff is clear, zero when set
// - fifo disabled after reset, configure changes it
//
// Design decision made here: the APB interface to the registers.
module fcp_top #(
    parameter int ADDR_W        = 12,
    parameter int STEP_RATE_CYC = fcp_pkg::STEP_RATE_CYC
) (
    input  wire logic              clk,          // 40 MHz clock
    input  wire logic              rst_n,        // async reset, active low
    input  wire logic              psel,         // apb select
    input  wire logic              penable,      // apb enable
    input  wire logic              pwrite,       // apb direction
    input  wire logic [ADDR_W-1:0] paddr,        // apb byte address
    input  wire logic [31:0]       pwdata,       // apb write data
    input  wire logic [3:0]        pstrb,        // apb byte strobes
    output logic      [31:0]       prdata,       // apb read data
    output logic                   pready,       // apb ready
    output logic                   pslverr,      // apb error
    input  wire logic              second_unit_present_n, // 0 installed
    input  wire logic              track0,       // head at track 0
    input  wire logic              index_pulse,  // index hole
    input  wire logic              write_protect, // disk protected
    input  wire logic              disk_change,  // media changed
    output logic                   step_out,     // step pulse
    output logic                   dir_out,      // 1 inward
    output logic                   head_out,     // side select
    output logic      [1:0]        unit_sel,     // drive select
    output logic      [3:0]        motor_en,     // motor enables
    output logic                   irq           // interrupt level
);
    initial begin
        if (ADDR_W < 6)
            $error("address too narrow for register map");
    end

    // pin synchronisers
    logic [4:0] pin_s1_ff;
    logic [4:0] pin_s2_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_ff <= 5'h00;
            pin_s2_ff <= 5'h00;
        end else begin
            pin_s1_ff <= {disk_change, write_protect, index_pulse,
                          track0, second_unit_present_n};
            pin_s2_ff <= pin_s1_ff;
        end
    end
    logic sec_n_s, trk0_s, idx_s, wp_s, chg_s;
    assign {chg_s, wp_s, idx_s, trk0_s, sec_n_s} = pin_s2_ff;

    // apb slave: zero wait, answer registered in the setup cycle
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic [3:0]  idx;
    logic        mapped;
    logic        setup;
    logic        done;
    logic        wr_done;
    logic        rd_done;
    logic [7:0]  rd_byte;
    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;
    assign idx     = paddr[5:2];
    assign setup   = psel & ~penable;
    assign done    = psel & penable & pready_ff;
    assign wr_done = done & pwrite & pstrb[0] & mapped;
    assign rd_done = done & ~pwrite & mapped;

    function automatic logic is_mapped(input logic [3:0] i,
                                       input logic [ADDR_W-1:0] a);
        logic ok;
        ok = (a[1:0] == 2'b00) && (a[ADDR_W-1:6] == '0);
        is_mapped = ok && (i != 4'h6) && (i <= fcp_pkg::IDX_MODE);
    endfunction
    assign mapped = is_mapped(idx, paddr);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_ff  <= 32'h0000_0000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= setup;
            pslverr_ff <= setup & ~mapped;
            if (setup)
                prdata_ff <= {24'h00_0000, rd_byte};
        end
    end

    // software registers
    logic [7:0]       motor_ff;
    logic [1:0]       tape_ff;
    logic [7:0]       rate_ff;
    logic             model30_ff;
    localparam int IRQ_W_L = fcp_pkg::IRQ_W - 1;
    logic [IRQ_W_L:0] irq_stat_ff;
    logic [IRQ_W_L:0] irq_mask_ff;
    logic [IRQ_W_L:0] irq_set;
    logic             irq_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            motor_ff    <= 8'h00;
            tape_ff     <= 2'b00;
            rate_ff     <= 8'h00;
            model30_ff  <= 1'b0;
            irq_mask_ff <= '0;
        end else if (wr_done) begin
            case (idx)
                fcp_pkg::IDX_MOTOR:    motor_ff    <= pwdata[7:0];
                fcp_pkg::IDX_TAPE:     tape_ff     <= pwdata[1:0];
                fcp_pkg::IDX_FLOW,
                fcp_pkg::IDX_CHANGE:   rate_ff     <= pwdata[7:0];
                fcp_pkg::IDX_IRQ_MASK: irq_mask_ff <= pwdata[IRQ_W_L:0];
                fcp_pkg::IDX_MODE:     model30_ff  <= pwdata[0];
                default: ;
            endcase
        end
    end

    // sticky status, write one to clear, set wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_ff <= '0;
            irq_ff      <= 1'b0;
        end else begin
            if (wr_done && idx == fcp_pkg::IDX_IRQ_STAT)
                irq_stat_ff <= (irq_stat_ff & ~pwdata[IRQ_W_L:0]) | irq_set;
            else
                irq_stat_ff <= irq_stat_ff | irq_set;
            irq_ff <= |(irq_stat_ff & irq_mask_ff);
        end
    end
    assign irq      = irq_ff;
    assign motor_en = motor_ff[7:4];
    assign unit_sel = motor_ff[1:0];

    // command machine state
    fcp_pkg::fcp_state_e state_ff;
    logic [7:0] cmd_ff [4];
    logic [2:0] cnt_ff;
    logic       go_ff;
    logic [7:0] res_ff [fcp_pkg::RES_MAX];
    logic [3:0] res_len_ff;
    logic [3:0] res_idx_ff;
    logic [7:0] pcn_ff [4];
    logic [7:0] cfg_ff;
    logic [7:0] precomp_start_cylinder_ff;
    logic [6:0] perp_ff;
    logic       lock_ff;
    logic       head_ff;
    logic [1:0] unit_ff;
    logic       seek_start;
    logic [7:0] seek_tgt;
    logic       st_step, st_dir, st_busy, st_done;
    logic [7:0] st_track;

    function automatic logic [2:0] cmd_len(input logic [7:0] op);
        if (op == fcp_pkg::OP_SEEK ||
            (op[7] && op[5:0] == fcp_pkg::OP_RSEEK_LOW))
            cmd_len = 3'd3;
        else if (op == fcp_pkg::OP_CONFIG)
            cmd_len = 3'd4;
        else if (op == fcp_pkg::OP_PERP || op == fcp_pkg::OP_SENSE)
            cmd_len = 3'd2;
        else
            cmd_len = 3'd1;
    endfunction

    function automatic logic is_seek(input logic [7:0] op);
        is_seek = (op == fcp_pkg::OP_SEEK) ||
                  (op[7] && op[5:0] == fcp_pkg::OP_RSEEK_LOW);
    endfunction

    logic data_wr;
    logic data_rd;
    assign data_wr = wr_done && idx == fcp_pkg::IDX_DATA;
    assign data_rd = rd_done && idx == fcp_pkg::IDX_DATA;

    // relative target saturates at the ends of the track range
    logic [8:0] rel_sum;
    always_comb begin
        rel_sum = 9'h000;
        if (cmd_ff[0][6])
            rel_sum = {1'b0, pcn_ff[cmd_ff[1][1:0]]} + {1'b0, cmd_ff[2]};
        else if (pcn_ff[cmd_ff[1][1:0]] > cmd_ff[2])
            rel_sum = {1'b0, pcn_ff[cmd_ff[1][1:0]] - cmd_ff[2]};
        if (rel_sum[8])
            rel_sum = 9'h0FF;
        if (cmd_ff[0] == fcp_pkg::OP_SEEK)
            seek_tgt = cmd_ff[2];
        else
            seek_tgt = rel_sum[7:0];
    end
    assign seek_start = go_ff && is_seek(cmd_ff[0]);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff   <= fcp_pkg::ST_IDLE;
            cnt_ff     <= 3'd0;
            go_ff      <= 1'b0;
            res_len_ff <= 4'd0;
            res_idx_ff <= 4'd0;
            cfg_ff     <= fcp_pkg::CFG_RST;
            precomp_start_cylinder_ff  <= fcp_pkg::PRECOMP_START_CYLINDER_RST;
            perp_ff    <= 7'h00;
            lock_ff    <= 1'b0;
            head_ff    <= 1'b0;
            unit_ff    <= 2'b00;
            for (int i = 0; i < 4; i++) begin
                cmd_ff[i] <= 8'h00;
                pcn_ff[i] <= 8'h00;
            end
            for (int i = 0; i < fcp_pkg::RES_MAX; i++)
                res_ff[i] <= 8'h00;
        end else begin
            go_ff <= 1'b0;
            case (state_ff)
                fcp_pkg::ST_IDLE,
                fcp_pkg::ST_PARAM: begin
                    if (data_wr) begin
                        cmd_ff[cnt_ff[1:0]] <= pwdata[7:0];
                        if (cnt_ff + 3'd1 == cmd_len(state_ff ==
                                fcp_pkg::ST_IDLE ? pwdata[7:0] : cmd_ff[0]))
                        begin
                            go_ff    <= 1'b1;
                            cnt_ff   <= 3'd0;
                            state_ff <= fcp_pkg::ST_EXEC;
                        end else begin
                            cnt_ff   <= cnt_ff + 3'd1;
                            state_ff <= fcp_pkg::ST_PARAM;
                        end
                    end
                end
                fcp_pkg::ST_EXEC: begin
                    res_idx_ff <= 4'd0;
                    if (go_ff) begin
                        if (is_seek(cmd_ff[0])) begin
                            head_ff <= cmd_ff[1][2];
                            unit_ff <= cmd_ff[1][1:0];
                        end else if (cmd_ff[0] == fcp_pkg::OP_CONFIG) begin
                            cfg_ff    <= {1'b0, cmd_ff[2][6:0]};
                            precomp_start_cylinder_ff <= cmd_ff[3];
                            state_ff  <= fcp_pkg::ST_IDLE;
                        end else if (cmd_ff[0] == fcp_pkg::OP_PERP) begin
                            if (cmd_ff[1][7])
                                perp_ff[5:2] <= cmd_ff[1][5:2];
                            perp_ff[1:0] <= cmd_ff[1][1:0];
                            state_ff     <= fcp_pkg::ST_IDLE;
                        end else if (cmd_ff[0] == fcp_pkg::OP_DUMP) begin
                            for (int i = 0; i < 4; i++)
                                res_ff[i] <= pcn_ff[i];
                            res_ff[4] <= fcp_pkg::TIMING_RST;
                            res_ff[5] <= fcp_pkg::MODEB_RST;
                            res_ff[6] <= fcp_pkg::SECT_RST;
                            res_ff[7] <= {lock_ff, 1'b0,
                                          perp_ff[5:0]};
                            res_ff[8] <= cfg_ff;
                            res_ff[9] <= precomp_start_cylinder_ff;
                            res_len_ff <= 4'(fcp_pkg::RES_MAX);
                            state_ff   <= fcp_pkg::ST_RESULT;
                        end else if (cmd_ff[0][6:0] ==
                                     fcp_pkg::OP_LOCK_LOW) begin
                            lock_ff    <= cmd_ff[0][7];
                            res_ff[0]  <= {3'b000, cmd_ff[0][7], 4'h0};
                            res_len_ff <= 4'd1;
                            state_ff   <= fcp_pkg::ST_RESULT;
                        end else if (cmd_ff[0] == fcp_pkg::OP_SENSE) begin
                            res_ff[0]  <= {1'b0, wp_s, 1'b1, trk0_s,
                                           1'b1, cmd_ff[1][2:0]};
                            res_len_ff <= 4'd1;
                            state_ff   <= fcp_pkg::ST_RESULT;
                        end else begin
                            res_ff[0]  <= fcp_pkg::INVALID_ST0;
                            res_len_ff <= 4'd1;
                            state_ff   <= fcp_pkg::ST_RESULT;
                        end
                    end else if (st_done) begin
                        pcn_ff[unit_ff] <= st_track;
                        state_ff        <= fcp_pkg::ST_IDLE;
                    end
                end
                fcp_pkg::ST_RESULT: begin
                    if (data_rd) begin
                        res_idx_ff <= res_idx_ff + 4'd1;
                        if (res_idx_ff + 4'd1 == res_len_ff)
                            state_ff <= fcp_pkg::ST_IDLE;
                    end
                end
                default: state_ff <= fcp_pkg::ST_IDLE;
            endcase
        end
    end
    assign head_out = head_ff;

    // interrupt events
    always_comb begin
        irq_set = '0;
        irq_set[fcp_pkg::IRQ_SEEK] = st_done;
        irq_set[fcp_pkg::IRQ_RESULT] = go_ff && cmd_len(cmd_ff[0]) != 3'd0
            && !is_seek(cmd_ff[0]) && cmd_ff[0] != fcp_pkg::OP_CONFIG
            && cmd_ff[0] != fcp_pkg::OP_PERP;
        irq_set[fcp_pkg::IRQ_INVALID] = go_ff && cmd_len(cmd_ff[0]) == 3'd1
            && cmd_ff[0] != fcp_pkg::OP_DUMP
            && cmd_ff[0][6:0] != fcp_pkg::OP_LOCK_LOW;
    end

    fcp_stepper #(
        .RATE_CYC  (STEP_RATE_CYC),
        .PULSE_CYC (fcp_pkg::STEP_PULSE_CYC)
    ) u_stepper (
        .clk         (clk),
        .rst_n       (rst_n),
        .start       (seek_start),
        .start_track (pcn_ff[cmd_ff[1][1:0]]),
        .target      (seek_tgt),
        .step_ff     (st_step),
        .dir_ff      (st_dir),
        .busy_ff     (st_busy),
        .done_ff     (st_done),
        .track_ff    (st_track)
    );
    assign step_out = st_step;
    assign dir_out  = st_dir;

    // read mux
    logic [7:0] mon_a;
    logic [7:0] flow;
    always_comb begin
        if (model30_ff)
            mon_a = {irq_ff, 1'b0, st_step, ~trk0_s, head_ff,
                     ~idx_s, wp_s, ~st_dir};
        else
            mon_a = {irq_ff, sec_n_s, ~st_step, trk0_s,
                     ~head_ff, idx_s, ~wp_s, st_dir};
        flow = {state_ff != fcp_pkg::ST_PARAM &&
                    state_ff != fcp_pkg::ST_EXEC ||
                    state_ff == fcp_pkg::ST_PARAM,
                state_ff == fcp_pkg::ST_RESULT,
                state_ff == fcp_pkg::ST_EXEC,
                state_ff != fcp_pkg::ST_IDLE,
                3'b000, st_busy};
        case (idx)
            fcp_pkg::IDX_MON_A:    rd_byte = mon_a;
            fcp_pkg::IDX_MON_B:    rd_byte = {2'b11, motor_ff[0], 3'b000,
                                              ~motor_ff[5:4]};
            fcp_pkg::IDX_TAPE:     rd_byte = {6'h00, tape_ff};
            fcp_pkg::IDX_FLOW:     rd_byte = flow;
            fcp_pkg::IDX_DATA:     rd_byte =
                (state_ff == fcp_pkg::ST_RESULT) ? res_ff[res_idx_ff] : 8'h00;
            fcp_pkg::IDX_CHANGE:   rd_byte = {chg_s, 7'h00};
            fcp_pkg::IDX_IRQ_STAT: rd_byte = 8'(irq_stat_ff);
            fcp_pkg::IDX_IRQ_MASK: rd_byte = 8'(irq_mask_ff);
            fcp_pkg::IDX_MODE:     rd_byte = {7'h00, model30_ff};
            default:               rd_byte = 8'h00;
        endcase
    end
endmodule

// [bench/fcp_top_props.sv]
// concurrent checks on the apb port map and stepper outputs
module fcp_top_props #(
    parameter int ADDR_W = 12
) (
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              step_out,
    input wire logic              dir_out,
    input wire logic [1:0]        unit_sel,
    input wire logic [3:0]        motor_en,
    input wire logic              irq
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire setup = psel && !penable;
    wire done = psel && penable && pready;
    property p_ready; setup |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("ready late");
    property p_ready_src; pready |-> $past(setup); endproperty
    a_ready_src: assert property (p_ready_src) else $error("stray ready");
    property p_unmapped; setup && paddr[5:2] == 4'h6 |=> pslverr; endproperty
    a_unmapped: assert property (p_unmapped) else $error("no error");
    property p_mapped;
        setup && paddr[5:2] == 4'h5 && paddr[1:0] == 2'b00
            && paddr[ADDR_W-1:6] == '0 |=> !pslverr;
    endproperty
    a_mapped: assert property (p_mapped) else $error("bad error");
    property p_irq_bit;
        setup && !pwrite && paddr == '0 |=> prdata[7] == $past(irq);
    endproperty
    a_irq_bit: assert property (p_irq_bit) else $error("irq bit");
    property p_step_w; $rose(step_out) |-> step_out[*4] ##1 !step_out;
    endproperty
    a_step_w: assert property (p_step_w) else $error("step width");
    property p_dir_hold; step_out && $past(step_out) |-> $stable(dir_out);
    endproperty
    a_dir_hold: assert property (p_dir_hold) else $error("dir moved");
    property p_motor;
        done && pwrite && paddr[5:2] == 4'h2 |=> unit_sel ==
            $past(pwdata[1:0]) && motor_en == $past(pwdata[7:4]);
    endproperty
    a_motor: assert property (p_motor) else $error("motor reg");
    property p_upper; pready |-> prdata[31:8] == 24'h000000; endproperty
    a_upper: assert property (p_upper) else $error("upper bits");
    c_step: cover property ($rose(step_out));
    c_err: cover property (pslverr);
    c_irq: cover property ($rose(irq));
endmodule

bind fcp_top fcp_top_props #(.ADDR_W(ADDR_W)) u_props (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .step_out(step_out),
    .dir_out(dir_out), .unit_sel(unit_sel), .motor_en(motor_en), .irq(irq));

// [bench/fcp_drive_model.sv]
// diskette drive model: head position, track zero and index
module fcp_drive_model (
    input  wire logic clk,         // system clock
    input  wire logic rst_n,       // async reset, active low
    input  wire logic step_out,    // step from controller
    input  wire logic dir_out,     // 1 inward
    output logic      track0,      // head at track 0
    output logic      index_pulse  // index hole
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] pos_ff;
    logic [5:0] cnt_ff;
    logic       step_q_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pos_ff <= 8'h00;
            cnt_ff <= 6'h00;
            step_q_ff <= 1'b0;
        end else begin
            step_q_ff <= step_out;
            cnt_ff <= cnt_ff + 6'h01;
            if (step_out && !step_q_ff)
                pos_ff <= dir_out ? pos_ff + 8'h01 : pos_ff - 8'h01;
        end
    end
    assign track0 = (pos_ff == 8'h00);
    assign index_pulse = (cnt_ff == 6'h00);
endmodule

// [bench/floppy_command_and_port_map_tb_top.sv]
// self-checking bench: commands and ports over apb
module floppy_command_and_port_map_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic [3:0] pstrb = 4'hF, motor_en;
    logic pready, pslverr, sec_n = 0, wp = 1, dc = 1, err;
    logic track0, index_pulse, step_out, dir_out, head_out, irq;
    logic [1:0] unit_sel;
    logic [7:0] rd, dexp [10];
    int n_mismatch = 0, num_checks = 0;
    always #12.5 clk = ~clk;
    fcp_top #(.STEP_RATE_CYC(20)) u_fcp_top (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .second_unit_present_n(sec_n), .track0(track0),
        .index_pulse(index_pulse), .write_protect(wp), .disk_change(dc),
        .step_out(step_out), .dir_out(dir_out), .head_out(head_out),
        .unit_sel(unit_sel), .motor_en(motor_en), .irq(irq));
    fcp_drive_model u_fcp_drive_model (.clk(clk), .rst_n(rst_n),
        .step_out(step_out), .dir_out(dir_out), .track0(track0),
        .index_pulse(index_pulse));
    task automatic apb(input logic w, input logic [3:0] idx,
                       input logic [7:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {6'h00, idx, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic chk(input string nm, input logic [7:0] e, got);
        num_checks++;
        if (got !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, got);
        end
    endtask
    task automatic rchk(input logic [3:0] i, input logic [7:0] e, m);
        apb(1'b0, i, 8'h00);
        chk("read", e, rd & m);
    endtask
    task automatic dump_chk;
        apb(1'b1, fcp_pkg::IDX_DATA, fcp_pkg::OP_DUMP);
        for (int i = 0; i < 10; i++) rchk(fcp_pkg::IDX_DATA, dexp[i], 8'hFF);
    endtask
    task automatic wait_seek;
        rd = 8'h00;
        for (int i = 0; i < 100 && rd[0] !== 1'b1; i++)
            apb(1'b0, fcp_pkg::IDX_IRQ_STAT, 8'h00);
        chk("seek_done", 8'h01, {7'h00, rd[0]});
        apb(1'b1, fcp_pkg::IDX_IRQ_STAT, 8'h01);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #(25 * 20000);
        n_mismatch++;
        final_report();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        dexp = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                 8'h20, 8'h00};
        dump_chk();
        apb(1'b1, fcp_pkg::IDX_TAPE, 8'h03);
        rchk(fcp_pkg::IDX_TAPE, 8'h03, 8'h03);
        apb(1'b1, fcp_pkg::IDX_MOTOR, 8'h31);
        chk("motor", 8'h31, {motor_en, 2'b00, unit_sel});
        apb(1'b0, 4'h6, 8'h00);
        chk("slverr", 8'h01, {7'h00, err});
        rchk(fcp_pkg::IDX_CHANGE, 8'h80, 8'h80);
        foreach (dexp[i]) dexp[i] = 8'h00;
        apb(1'b1, 4'h5, 8'h13);
        apb(1'b1, 4'h5, 8'h00);
        apb(1'b1, 4'h5, 8'h4F);
        apb(1'b1, 4'h5, 8'h33);
        repeat (2) @(posedge clk);
        rchk(fcp_pkg::IDX_FLOW, 8'h80, 8'hD0);
        apb(1'b1, 4'h5, 8'h12);
        apb(1'b1, 4'h5, 8'h84);
        apb(1'b1, 4'h5, 8'h94);
        rchk(fcp_pkg::IDX_DATA, 8'h10, 8'hFF);
        apb(1'b1, 4'h5, fcp_pkg::OP_SEEK);
        apb(1'b1, 4'h5, 8'h01);
        apb(1'b1, 4'h5, 8'h03);
        wait_seek();
        chk("irq_masked", 8'h00, {7'h00, irq});
        apb(1'b1, 4'h5, 8'hCF);
        apb(1'b1, 4'h5, 8'h01);
        apb(1'b1, 4'h5, 8'h02);
        wait_seek();
        apb(1'b1, fcp_pkg::IDX_IRQ_STAT, 8'h01);
        apb(1'b1, fcp_pkg::IDX_IRQ_MASK, 8'h02);
        @(posedge clk);
        chk("irq_set", 8'h01, {7'h00, irq});
        rchk(fcp_pkg::IDX_MON_A, 8'hA9, 8'hFB);
        apb(1'b1, fcp_pkg::IDX_IRQ_STAT, 8'h02);
        repeat (2) @(posedge clk);
        chk("irq_clr", 8'h00, {7'h00, irq});
        dexp = '{8'h00, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h84,
                 8'h4F, 8'h33};
        dump_chk();
        apb(1'b1, 4'h5, fcp_pkg::OP_SENSE);
        apb(1'b1, 4'h5, 8'h05);
        rchk(fcp_pkg::IDX_DATA, 8'h6D, 8'hFF);
        apb(1'b1, 4'h5, 8'hFF);
        rchk(fcp_pkg::IDX_DATA, fcp_pkg::INVALID_ST0, 8'hFF);
        rchk(fcp_pkg::IDX_FLOW, 8'h80, 8'hD0);
        final_report();
    end
endmodule
